// file: hw/lowest_pick.sv
// Fixed-priority picker: returns the lowest set index of a request vector.
`timescale 1ns/1ps
module lowest_pick #(
  parameter int N = 14,
  parameter int W = 4
) (
  // Requests and answer.
  input  wire logic [N-1:0] req_i,
  output logic              hit_o,
  output logic [W-1:0]      idx_o
);

  // Scan from the top so the lowest request is the last to win.
  always_comb begin
    hit_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        hit_o = 1'b1;
        idx_o = W'(i);
      end
    end
  end

endmodule

// file: hw/van_channel_tx_scheduler.sv
// Channel arbitration, retry, rearbitrate, abort and mode control of the line controller.
`timescale 1ns/1ps
`include "van_sched_defs.svh"
module van_channel_tx_scheduler #(
  parameter int NCH = `NUM_CHAN
) (
  // Clock and reset.
  input  wire logic                    clock_i,
  input  wire logic                    rstn_i,
  // Host register port.
  input  wire van_sched_pkg::host_req_s host_i,
  output logic [7:0]                   host_rdata_o,
  // Receive identifier from the line engine.
  input  wire logic                    rx_id_valid_i,
  input  wire logic [7:0]              rx_id_i,
  output van_sched_pkg::area_s         rx_area_o,
  // Transmit request and attempt result.
  output logic                         tx_req_o,
  output van_sched_pkg::area_s         tx_area_o,
  input  wire van_sched_pkg::attempt_s attempt_i,
  // Line and clock control.
  output logic                         txd_oe_o,
  output logic                         clock_run_o
);
  import van_sched_pkg::*;

  // Byte address of one channel register.
  function automatic logic [7:0] chan_word(input logic [3:0] ch, input logic [1:0] off);
    chan_word = `CH_BASE + {2'b00, ch, off};
  endfunction

  // Channel whose pointer and length describe the message area.
  function automatic logic [3:0] link_target(input logic [4:0] len, input logic [6:0] ptr,
                                             input logic [3:0] self);
    if (len == 5'h00 && ptr < 7'(NCH)) link_target = ptr[3:0];
    else link_target = self;
  endfunction

  // Per-channel host registers.
  logic [7:0] tag_r [NCH];
  logic [6:0] ptr_r [NCH];
  logic [4:0] len_r [NCH];
  logic [NCH-1:0] prod_r, sent_r, rcvd_r, abort_r;
  // Global registers and scheduler state.
  logic [3:0] limit_r, cmd_r;
  logic [2:0] fail_r;
  logic       irq_r, rearb_r;
  logic [3:0] cnt_r, retries_r, cur_r, post_r;
  logic       post_v_r;
  mode_e      mode_r;
  tx_state_e  state_r;
  logic [7:0] rdata_r;
  area_s      tx_area_r, rx_area_r;
  logic       txd_oe_r, clk_run_r;

  // Hardware set requests toward the channel flags.
  logic [NCH-1:0] set_sent, set_rcvd, rx_match, tx_ready, tx_cand;
  logic           rx_hit, tx_hit, in_send, attempt_end;
  logic [3:0]     rx_idx, tx_idx;

  // Receive matching among active consumer channels.
  for (genvar g = 0; g < NCH; g++) begin : g_match
    assign rx_match[g] = ~prod_r[g] & ~rcvd_r[g] & (tag_r[g] == rx_id_i);
    assign tx_ready[g] = prod_r[g] & ~sent_r[g];
    assign tx_cand[g]  = tx_ready[g] & ~(in_send && cur_r == 4'(g)) & ~(post_v_r && post_r == 4'(g));
  end

  lowest_pick #(.N(NCH), .W(4)) u_rx_pick (
    .req_i (rx_match),
    .hit_o (rx_hit),
    .idx_o (rx_idx)
  );

  lowest_pick #(.N(NCH), .W(4)) u_tx_pick (
    .req_i (tx_cand),
    .hit_o (tx_hit),
    .idx_o (tx_idx)
  );

  // Mode and command decoding.
  wire is_active   = (mode_r == MODE_ACTIVE);
  wire rx_take     = is_active & rx_id_valid_i & rx_hit;
  wire idle_req    = cmd_r[`CMD_IDLE_BIT] | ~cmd_r[`CMD_ACT_BIT];
  wire sleep_req   = cmd_r[`CMD_SLEEP_BIT];
  wire cmd_wr      = host_i.wr & (host_i.addr == `ADDR_MODE_CMD);
  wire irq_rd      = host_i.rd & (host_i.addr == `ADDR_IRQ_FLAGS);
  assign in_send     = (state_r == ST_SEND);
  assign attempt_end = in_send & attempt_i.done;

  // Outcome of the attempt that just ended.
  wire att_fail    = attempt_i.cv | attempt_i.acknowledge_failure_flag | attempt_i.checksum_failure_flag;
  wire counted     = ~attempt_i.ok & ~attempt_i.contention & att_fail;
  wire exhausted   = counted & (cnt_r == 4'h0);
  wire cur_abort   = abort_r[cur_r];
  wire finished    = attempt_i.ok | exhausted | cur_abort;
  wire do_rearb    = rearb_r & ~finished & tx_hit & (tx_idx < cur_r);
  wire post_alive  = tx_ready[post_r];
  wire resume      = post_v_r & post_alive;
  wire start_new   = ~post_v_r & tx_hit & ~idle_req;
  wire can_start   = is_active & ~in_send & (resume | start_new);
  wire [3:0] start_ch = resume ? post_r : tx_idx;

  // Host register write strobes decoded once per channel.
  logic [NCH-1:0] wr_tag, wr_ctrl, wr_ptr, wr_len, abort_ok;
  for (genvar g = 0; g < NCH; g++) begin : g_wr
    assign wr_tag[g]   = host_i.wr & (host_i.addr == chan_word(4'(g), `CH_OFF_TAG));
    assign wr_ctrl[g]  = host_i.wr & (host_i.addr == chan_word(4'(g), `CH_OFF_CTRL));
    assign wr_ptr[g]   = host_i.wr & (host_i.addr == chan_word(4'(g), `CH_OFF_PTR));
    assign wr_len[g]   = host_i.wr & (host_i.addr == chan_word(4'(g), `CH_OFF_LEN));
    assign abort_ok[g] = wr_ptr[g] & host_i.wdata[`PTR_ABORT_BIT] & prod_r[g] & ~sent_r[g];
    assign set_rcvd[g] = rx_take & (rx_idx == 4'(g));
    // Abort of an idle channel lands at once; of the sending one at the attempt end.
    assign set_sent[g] = (abort_ok[g] & ~(in_send && cur_r == 4'(g)))
                       | (attempt_end & finished & cur_r == 4'(g));
  end

  // Enabling any producer channel while nothing is sent loads the shared counter.
  wire enable_wr = |(wr_len & ~{NCH{host_i.wdata[`LEN_SENT_BIT]}} & prod_r);

  // Per-channel registers; hardware sets win over host writes.
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
        tag_r[g]   <= 8'h00;
        ptr_r[g]   <= 7'h00;
        len_r[g]   <= 5'h00;
        prod_r[g]  <= 1'b0;
        sent_r[g]  <= 1'b1;
        rcvd_r[g]  <= 1'b1;
        abort_r[g] <= 1'b0;
      end else begin
        if (wr_tag[g]) tag_r[g] <= host_i.wdata;
        if (wr_ctrl[g]) prod_r[g] <= host_i.wdata[`CTRL_PROD_BIT];
        if (wr_ptr[g]) ptr_r[g] <= host_i.wdata[6:0];
        if (wr_len[g]) len_r[g] <= host_i.wdata[4:0];
        sent_r[g]  <= set_sent[g] | (wr_len[g] ? host_i.wdata[`LEN_SENT_BIT] : sent_r[g]);
        rcvd_r[g]  <= set_rcvd[g] | (wr_len[g] ? host_i.wdata[`LEN_RCVD_BIT] : rcvd_r[g]);
        abort_r[g] <= abort_ok[g] | (abort_r[g] & ~set_sent[g]);
      end
    end
  end

  // Mode command register; rearbitrate is kept only while a channel is sending.
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      cmd_r   <= `CMD_RESET;
      rearb_r <= 1'b0;
      limit_r <= `RETRY_RESET;
    end else begin
      if (cmd_wr) cmd_r <= {1'b0, host_i.wdata[2:0]};
      if (host_i.wr && host_i.addr == `ADDR_TX_CTRL) limit_r <= host_i.wdata[3:0];
      if (cmd_wr && host_i.wdata[`CMD_REARB_BIT] && in_send) rearb_r <= 1'b1;
      else if (attempt_end || !in_send) rearb_r <= 1'b0;
    end
  end

  // Operating mode: sleep wins, idle waits for every pending attempt.
  mode_e mode_nxt;
  always_comb begin
    mode_nxt = mode_r;
    if (sleep_req) mode_nxt = MODE_SLEEP;
    else if (!idle_req) mode_nxt = MODE_ACTIVE;
    else if (!in_send && !post_v_r) mode_nxt = MODE_IDLE;
    else if (mode_r == MODE_SLEEP) mode_nxt = MODE_IDLE;
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) mode_r <= MODE_IDLE;
    else mode_r <= mode_nxt;
  end

  // Transmit scheduler, retry counter and postponed channel.
  always_ff @(posedge clock_i) begin
    if (!rstn_i || mode_r == MODE_SLEEP) begin
      state_r   <= ST_WAIT;
      cnt_r     <= 4'h0;
      retries_r <= 4'h0;
      cur_r     <= 4'h0;
      post_r    <= 4'h0;
      post_v_r  <= 1'b0;
    end else if (state_r == ST_WAIT) begin
      if (enable_wr) cnt_r <= limit_r;
      if (post_v_r && !post_alive) post_v_r <= 1'b0;
      if (can_start) begin
        state_r   <= ST_SEND;
        cur_r     <= start_ch;
        cnt_r     <= limit_r;
        retries_r <= 4'h0;
        if (resume) post_v_r <= 1'b0;
      end
    end else if (attempt_i.done) begin
      if (do_rearb) begin
        post_r    <= cur_r;
        post_v_r  <= 1'b1;
        cur_r     <= tx_idx;
        cnt_r     <= limit_r;
        retries_r <= 4'h0;
      end else if (finished) begin
        state_r <= ST_WAIT;
      end else if (counted) begin
        cnt_r     <= cnt_r - 4'h1;
        retries_r <= retries_r + 4'h1;
      end
    end
  end

  // Failure cause and transmit-failure flag; a new failure beats a read clear.
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      fail_r <= 3'h0;
      irq_r  <= 1'b0;
    end else begin
      if (attempt_end && counted) fail_r <= {attempt_i.checksum_failure_flag, attempt_i.acknowledge_failure_flag, attempt_i.cv};
      irq_r <= (attempt_end & exhausted) | (irq_r & ~irq_rd);
    end
  end

  // Read selection of the global and channel registers.
  wire [7:0] rel     = host_i.addr - `CH_BASE;
  wire [3:0] rd_ch   = rel[5:2];
  wire       rd_chan = (host_i.addr >= `CH_BASE) && (rd_ch < 4'(NCH)) && (rel[7:6] == 2'b00);
  wire [7:0] line_state = {4'h0, in_send, is_active, mode_r == MODE_SLEEP, mode_r == MODE_IDLE};
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (rd_chan) begin
      case (rel[1:0])
        `CH_OFF_TAG:  rd_mux = tag_r[rd_ch];
        `CH_OFF_CTRL: rd_mux = {7'h00, prod_r[rd_ch]};
        `CH_OFF_PTR:  rd_mux = {abort_r[rd_ch], ptr_r[rd_ch]};
        default:      rd_mux = {sent_r[rd_ch], rcvd_r[rd_ch], 1'b0, len_r[rd_ch]};
      endcase
    end else begin
      case (host_i.addr)
        `ADDR_TX_CTRL:    rd_mux = {4'h0, limit_r};
        `ADDR_MODE_CMD:   rd_mux = {4'h0, rearb_r, cmd_r[2:0]};
        `ADDR_LINE_STATE: rd_mux = line_state;
        `ADDR_TX_PROG:    rd_mux = {retries_r, cur_r};
        `ADDR_LAST_FAIL:  rd_mux = {5'h00, fail_r};
        `ADDR_IRQ_FLAGS:  rd_mux = {7'h00, irq_r};
        default:          rd_mux = 8'h00;
      endcase
    end
  end

  // Linkage resolution for the sending and the receiving channel.
  wire [3:0] tx_tgt = link_target(len_r[start_ch], ptr_r[start_ch], start_ch);
  wire [3:0] dr_tgt = link_target(len_r[tx_idx], ptr_r[tx_idx], tx_idx);
  wire [3:0] rx_tgt = link_target(len_r[rx_idx], ptr_r[rx_idx], rx_idx);

  // Output flops.
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_r   <= 8'h00;
      tx_area_r <= '0;
      rx_area_r <= '0;
      txd_oe_r  <= 1'b0;
      clk_run_r <= 1'b1;
    end else begin
      if (host_i.rd) rdata_r <= rd_mux;
      if (can_start) tx_area_r <= '{1'b1, start_ch, ptr_r[tx_tgt], len_r[tx_tgt]};
      else if (attempt_end && do_rearb) tx_area_r <= '{1'b1, tx_idx, ptr_r[dr_tgt], len_r[dr_tgt]};
      else if (attempt_end && finished) tx_area_r.valid <= 1'b0;
      rx_area_r <= '{rx_take, rx_idx, ptr_r[rx_tgt], len_r[rx_tgt]};
      txd_oe_r  <= (mode_nxt == MODE_ACTIVE);
      clk_run_r <= (mode_nxt != MODE_SLEEP);
    end
  end

  // Transmit request stands while a channel is scheduled.
  logic tx_req_r;
  always_ff @(posedge clock_i) begin
    if (!rstn_i || mode_r == MODE_SLEEP) tx_req_r <= 1'b0;
    else if (can_start) tx_req_r <= 1'b1;
    else if (attempt_end && finished && !do_rearb) tx_req_r <= 1'b0;
  end

  assign host_rdata_o = rdata_r;
  assign tx_req_o     = tx_req_r;
  assign tx_area_o    = tx_area_r;
  assign rx_area_o    = rx_area_r;
  assign txd_oe_o     = txd_oe_r;
  assign clock_run_o  = clk_run_r;

endmodule

// file: hw/van_sched_defs.svh
// Register offsets, field positions, reset values and counts of the scheduler.
// How it works
// - Lowest-numbered matching channel receives the frame.
// - Receiving channel goes inactive; next match takes later.
// - Lowest-numbered ready channel transmits first.
// - Retry, rearbitrate, abort apply to producer channels.
// - Enabling a channel loads counter from retry limit.
// - Failed attempt decrements; exhausted sets failure interrupt.
// - Retry limit N gives N plus one attempts.
// - Progress register shows retries done and channel.
// - Last failure register flags violation, acknowledge, checksum.
// - Lost contention never counts as a failure.
// - One counter and one limit serve all channels.
// - Rearbitrate postpones current channel, later resumes it.
// - Idle after rearbitrate waits for pending attempts.
// - Disabled postponed channel is dropped, not resumed.
// - Abort via channel bit honoured only if unsent.
// - Carried-out abort sets the channel sent flag.
// - Reset leaves idle: clock runs, transmit output released.
// - Line state register shows idle state.
// - Sleep bit wins; clock stops, internal state cleared.
// - Zero length links channel to pointer-named channel.
// - Transmit channel repeats until success or limit.
`ifndef VAN_SCHED_DEFS_SVH
`define VAN_SCHED_DEFS_SVH

`define NUM_CHAN        14
`define ADDR_TX_CTRL    8'h01
`define ADDR_MODE_CMD   8'h03
`define ADDR_LINE_STATE 8'h04
`define ADDR_TX_PROG    8'h05
`define ADDR_LAST_FAIL  8'h07
`define ADDR_IRQ_FLAGS  8'h09
`define CH_BASE         8'h10
`define CH_OFF_TAG      2'h0
`define CH_OFF_CTRL     2'h1
`define CH_OFF_PTR      2'h2
`define CH_OFF_LEN      2'h3

`define CMD_ACT_BIT     0
`define CMD_IDLE_BIT    1
`define CMD_SLEEP_BIT   2
`define CMD_REARB_BIT   3
`define CMD_RESET       4'h2

`define LS_IDLE_BIT     0
`define LS_SLEEP_BIT    1
`define LS_ACTIVE_BIT   2
`define LS_SEND_BIT     3

`define FAIL_CV_BIT     0
`define FAIL_ACK_BIT    1
`define FAIL_CRC_BIT    2
`define IRQ_TXFAIL_BIT  0

`define PTR_ABORT_BIT   7
`define LEN_SENT_BIT    7
`define LEN_RCVD_BIT    6
`define CTRL_PROD_BIT   0
`define RETRY_RESET     4'h0

`endif

// file: hw/van_sched_pkg.sv
// Types shared by the channel scheduler and its users.
package van_sched_pkg;

  // Operating modes of the controller.
  typedef enum logic [1:0] {MODE_IDLE, MODE_ACTIVE, MODE_SLEEP} mode_e;

  // Transmit scheduler states.
  typedef enum logic {ST_WAIT, ST_SEND} tx_state_e;

  // One host register access, one cycle long.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_s;

  // Result of one transmit attempt reported by the line engine.
  typedef struct packed {
    logic done;
    logic ok;
    logic contention;
    logic cv;
    logic acknowledge_failure_flag;
    logic checksum_failure_flag;
  } attempt_s;

  // Channel served and the message area it uses after linkage.
  typedef struct packed {
    logic       valid;
    logic [3:0] chan;
    logic [6:0] ptr;
    logic [4:0] len;
  } area_s;

endpackage

// file: verif/line_engine_model.sv
// Line engine model: ends each attempt with a chosen outcome after a chosen gap.
`timescale 1ns/1ps
module line_engine_model (
  // Clock and request.
  input wire logic             clock_i,
  input wire logic             tx_req_i,
  // Outcome 0 ok, 1 lost contention, 2 to 4 failure kinds; gap in cycles.
  input wire logic [2:0]       result_i,
  input wire logic [3:0]       gap_i,
  // Attempt result and attempt count.
  output van_sched_pkg::attempt_s attempt_o,
  output logic [7:0]           count_o
);
  import van_sched_pkg::*;
  logic [3:0] wait_r = '0;
  initial attempt_o = '0;
  initial count_o = '0;
  // One done pulse per attempt, never while the request is low.
  always @(posedge clock_i) begin
    attempt_o <= '0;
    if (!tx_req_i || attempt_o.done) begin
      wait_r <= '0;
    end else if (wait_r < gap_i) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      attempt_o <= '{1'b1, result_i == 3'd0, result_i == 3'd1, result_i == 3'd2, result_i == 3'd3, result_i == 3'd4};
      count_o <= count_o + 8'h01;
    end
  end
endmodule

// file: verif/van_channel_tx_scheduler_props.sv
// Port checker of the channel scheduler, bound to every instance.
`timescale 1ns/1ps
module van_channel_tx_scheduler_props #(
  parameter int NCH = 14
) (
  // Watched ports.
  input wire logic                    clock_i,
  input wire logic                    rstn_i,
  input wire van_sched_pkg::host_req_s host_i,
  input wire logic [7:0]              host_rdata_o,
  input wire logic                    rx_id_valid_i,
  input wire logic [7:0]              rx_id_i,
  input wire van_sched_pkg::area_s    rx_area_o,
  input wire logic                    tx_req_o,
  input wire van_sched_pkg::area_s    tx_area_o,
  input wire van_sched_pkg::attempt_s attempt_i,
  input wire logic                    txd_oe_o,
  input wire logic                    clock_run_o
);
  import van_sched_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Decoded host events.
  wire cmd_wr = host_i.wr && host_i.addr == 8'h03;
  wire end_try = tx_req_o && attempt_i.done && !host_i.wr;
  // Each assertion ties an output to its cause.
  a_reset_idle: assert property ($rose(rstn_i) |-> !tx_req_o && !txd_oe_o && clock_run_o)
    else $error("outputs busy after reset");
  a_sleep_clock_stop: assert property (cmd_wr && host_i.wdata[2] |=> ##1 (!clock_run_o && !txd_oe_o))
    else $error("sleep did not stop clock");
  a_frame_hold: assert property (tx_req_o && !attempt_i.done && !host_i.wr |=> tx_req_o && $stable(tx_area_o))
    else $error("channel changed inside an attempt");
  a_rdata_hold: assert property (!host_i.rd |=> $stable(host_rdata_o))
    else $error("read data moved without a read");
  a_contention_retry: assert property (end_try && attempt_i.contention |=> tx_req_o)
    else $error("lost contention ended the channel");
  a_success_end: assert property (end_try && attempt_i.ok |=> !tx_req_o || tx_area_o.chan != $past(tx_area_o.chan))
    else $error("channel sent again after success");
  a_rx_cause: assert property (rx_area_o.valid |-> $past(rx_id_valid_i))
    else $error("receive without identifier");
  a_start_driven: assert property ($rose(tx_req_o) |-> txd_oe_o)
    else $error("transmit started with line released");
  // Main scenarios.
  c_contention: cover property (attempt_i.done && attempt_i.contention);
  c_receive: cover property (rx_area_o.valid);
  c_sleep: cover property (!clock_run_o);
endmodule

bind van_channel_tx_scheduler van_channel_tx_scheduler_props #(.NCH(NCH)) u_props (
  .clock_i(clock_i), .rstn_i(rstn_i), .host_i(host_i), .host_rdata_o(host_rdata_o),
  .rx_id_valid_i(rx_id_valid_i), .rx_id_i(rx_id_i), .rx_area_o(rx_area_o), .tx_req_o(tx_req_o),
  .tx_area_o(tx_area_o), .attempt_i(attempt_i), .txd_oe_o(txd_oe_o), .clock_run_o(clock_run_o));

// file: verif/van_channel_tx_scheduler_tb.sv
// Self-checking bench of the channel scheduler.
`timescale 1ns/1ps
module van_channel_tx_scheduler_tb;
  import van_sched_pkg::*;
  logic       clock_i = 1'b0;
  logic       rstn_i = 1'b0;
  host_req_s  host_req = '0;
  logic [7:0] rdata;
  logic       rx_valid = 1'b0;
  logic [7:0] rx_id = 8'h3c;
  area_s      rx_area;
  logic       tx_req;
  area_s      tx_area;
  attempt_s   att;
  logic       txd_oe;
  logic       clk_run;
  logic [2:0] result = 3'd0;
  logic [3:0] gap = 4'd8;
  logic [7:0] cnt;
  logic [7:0] base = '0;
  int         error_cnt = 0;
  int         compares = 0;
  int         cycles = 0;

  always #20 clock_i = ~clock_i;

  van_channel_tx_scheduler dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .host_i(host_req), .host_rdata_o(rdata),
    .rx_id_valid_i(rx_valid), .rx_id_i(rx_id), .rx_area_o(rx_area), .tx_req_o(tx_req),
    .tx_area_o(tx_area), .attempt_i(att), .txd_oe_o(txd_oe), .clock_run_o(clk_run));
  line_engine_model far (
    .clock_i(clock_i), .tx_req_i(tx_req), .result_i(result), .gap_i(gap),
    .attempt_o(att), .count_o(cnt));

  task end_sim();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task tick();
    @(posedge clock_i);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // One host cycle: strobe for one edge, then release.
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    tick();
    host_req = '{w, !w, a, d};
    tick();
    host_req = '0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  function automatic logic [7:0] ch(input int n, input int o);
    return 8'(16 + 4 * n + o);
  endfunction
  // Waits for 0 attempt end, 1 request low, 2 request high.
  task wait_sig(input int s);
    int n;
    n = 0;
    tick();
    while (n < 500 && !(s == 0 ? att.done : (s == 1) ^ tx_req)) begin
      tick();
      n++;
    end
  endtask
  task rx(input int e, input logic v);
    tick();
    rx_valid = 1'b1;
    tick();
    rx_valid = 1'b0;
    chk("rx_valid", 8'(v), 8'(rx_area.valid));
    if (v)
      chk("rx_chan", 8'(e), 8'(rx_area.chan));
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    chk("clock_run", 8'h01, 8'(clk_run));
    chk("txd_oe", 8'h00, 8'(txd_oe));
    rchk(8'h04, 8'h01);
    rchk(8'h03, 8'h02);
    wr(8'h02, 8'hff);
    rchk(8'h02, 8'h00);
    // Channel 5 linked to channel 8; both made ready while idle.
    wr(ch(8, 1), 8'h01);
    wr(ch(8, 2), 8'h20);
    wr(ch(5, 1), 8'h01);
    wr(ch(5, 2), 8'h08);
    wr(ch(8, 3), 8'h04);
    wr(ch(5, 3), 8'h00);
    base = cnt;
    wr(8'h03, 8'h01);
    wait_sig(2);
    chk("tx_chan", 8'h05, 8'(tx_area.chan));
    chk("tx_ptr", 8'h20, 8'(tx_area.ptr));
    chk("tx_len", 8'h04, 8'(tx_area.len));
    chk("txd_oe", 8'h01, 8'(txd_oe));
    rchk(8'h04, 8'h0c);
    wait_sig(0);
    wait_sig(0);
    wait_sig(1);
    chk("attempts", 8'h02, cnt - base);
    rchk(ch(5, 3), 8'h80);
    rchk(ch(8, 3), 8'h84);
    // Each failure kind with its own retry limit.
    for (int k = 2; k < 5; k++) begin
      result = 3'(k);
      wr(8'h01, 8'(k - 2));
      base = cnt;
      wr(ch(8, 3), 8'h04);
      wait_sig(0);
      if (k > 2)
        rchk(8'h05, 8'h18);
      wait_sig(1);
      chk("attempts", 8'(k - 1), cnt - base);
      rchk(8'h07, 8'(1 << (k - 2)));
      rchk(8'h09, 8'h01);
      rchk(8'h09, 8'h00);
      rchk(ch(8, 3), 8'h84);
    end
    // Lost contention repeats without limit, then success ends it.
    result = 3'd1;
    gap = 4'd0;
    wr(8'h01, 8'h00);
    base = cnt;
    wr(ch(8, 3), 8'h04);
    repeat (30) tick();
    chk("busy", 8'h01, 8'(tx_req));
    chk("contend", 8'h01, 8'(cnt - base > 8'd8));
    result = 3'd0;
    wait_sig(1);
    rchk(8'h09, 8'h00);
    // Two consumers share one identifier.
    wr(ch(3, 0), 8'h3c);
    wr(ch(10, 0), 8'h3c);
    wr(ch(3, 3), 8'h84);
    wr(ch(10, 3), 8'h84);
    rx(3, 1'b1);
    rx(10, 1'b1);
    rx(0, 1'b0);
    rchk(ch(3, 3), 8'hc4);
    // Abort during the second attempt.
    result = 3'd2;
    gap = 4'd8;
    wr(8'h01, 8'h03);
    base = cnt;
    wr(ch(8, 3), 8'h04);
    wait_sig(0);
    wr(ch(8, 2), 8'ha0);
    wait_sig(1);
    chk("abort", 8'h02, cnt - base);
    rchk(ch(8, 3), 8'h84);
    wr(ch(8, 2), 8'h20);
    // Rearbitrate to channel 5, then idle requested.
    wr(8'h01, 8'h02);
    base = cnt;
    wr(ch(8, 3), 8'h04);
    wait_sig(0);
    wr(ch(5, 3), 8'h04);
    wr(8'h03, 8'h09);
    wait_sig(0);
    tick();
    chk("tx_chan", 8'h05, 8'(tx_area.chan));
    wr(8'h03, 8'h02);
    repeat (6) wait_sig(0);
    wait_sig(1);
    chk("attempts", 8'h08, cnt - base);
    rchk(8'h04, 8'h01);
    chk("txd_oe", 8'h00, 8'(txd_oe));
    // Sleep and wake.
    wr(8'h03, 8'h04);
    tick();
    chk("clock_run", 8'h00, 8'(clk_run));
    rchk(8'h04, 8'h02);
    wr(8'h03, 8'h01);
    tick();
    chk("clock_run", 8'h01, 8'(clk_run));
    rchk(8'h04, 8'h04);
    end_sim();
  end
endmodule
